// File: rtl/mss_seq.sv
// multi segment position sequencer with homing-done output timing
// assumes a trajectory generator that takes commands by valid/ready
// and reports the end of each segment with a one-cycle pulse
// Overview of operation
// [RL1] execution method picks one of six sequencing modes
// [RL2] sixteen segments stored; run spans first through last index
// [RL3] one-pass mode runs first to last in order, then stops
// [RL4] cyclic mode wraps to first until enable or servo drops
// [RL5] modes 2/3 run one segment chosen by inputs or register
// [RL6] continuous modes skip stopping between segments
// [RL7] first index 1..last, last index first..16, mutually clamped
// [RL8] after pause resume remaining segments or restart from first
// [RL9] position type selects relative or absolute targets
// [RL10] wait unit selects milliseconds or seconds
// [RL11] displacement signed 32-bit clamped to +-2147483646
// [RL12] per-segment max speed clamped 1..9000 rpm
// [RL13] per-segment ramp time 0..65535 ms passed with command
// [RL14] wait the segment's wait count before next segment
// [RL15] homing done output high for hold time then cleared
// [RL16] status bit 12 follows the homing done output
// [RL17] restart-effective settings apply only on restart
// [RL18] sequence-complete shown after last one-pass segment and wait
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "mss_cfg.svh"
module mss_seq #(
  parameter int CLK_PER_MS = `MSS_CLK_HZ / `MSS_MS_PER_S
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [9:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  output logic [31:0]        rdata_o,
  input  wire logic          servo_on_command_i,
  input  wire logic          pos_enable_i,
  input  wire logic          start_i,
  input  wire logic          pause_i,
  input  wire logic [3:0]    di_seg_sel_i,
  input  wire logic          cmd_ready_i,
  input  wire logic          seg_done_i,
  input  wire logic          homing_done_i,
  output logic               cmd_valid_o,
  output mss_pkg::mss_cmd_s  cmd_o,
  output logic               busy_o,
  output logic               seq_complete_o,
  output logic               homing_do_o,
  output logic               status_bit12_o,
  output logic               irq_o
);
  // ****************************************
  // configuration registers
  // ****************************************
  logic [15:0] homing_hold_time;
  logic [2:0]  method_pend;
  logic [2:0]  segment_exec_method;
  logic [4:0]  first_segment_index;
  logic [4:0]  last_segment_index;
  logic        resume_policy;
  logic        pos_pend;
  logic        position_reference_type;
  logic        wait_time_unit;
  logic [4:0]  comm_seg;
  logic [`MSS_IRQ_W-1:0] irq_st;
  logic [`MSS_IRQ_W-1:0] irq_en;
  logic signed [31:0] seg_disp  [`MSS_NSEG];
  logic [15:0]        seg_speed [`MSS_NSEG];
  logic [15:0]        seg_ramp  [`MSS_NSEG];
  logic [15:0]        seg_wait  [`MSS_NSEG];
  mss_pkg::mss_state_e state;
  mss_pkg::mss_state_e next_state;
  logic [4:0]  cur_idx;
  logic [4:0]  next_cur;
  logic [15:0] wait_cnt;
  logic [9:0]  sub_cnt;
  logic [14:0] tick_cnt;
  logic [15:0] hold_cnt;

  function automatic logic [4:0] clamp_idx(input logic [15:0] v,
                                           input logic [4:0]  lo,
                                           input logic [4:0]  hi);
    clamp_idx = (v < {11'h000, lo}) ? lo :
                (v > {11'h000, hi}) ? hi : v[4:0];
  endfunction

  // ****************************************
  // register port decode
  // ****************************************
  wire [15:0] wd16     = wdata_i[15:0];
  wire        wr_hold  = we_i && addr_i == `MSS_OFS_HOLD;
  wire        wr_meth  = we_i && addr_i == `MSS_OFS_METHOD;
  wire        wr_first = we_i && addr_i == `MSS_OFS_FIRST;
  wire        wr_last  = we_i && addr_i == `MSS_OFS_LAST;
  wire        wr_res   = we_i && addr_i == `MSS_OFS_RESUME;
  wire        wr_pos   = we_i && addr_i == `MSS_OFS_POSTYPE;
  wire        wr_wunit = we_i && addr_i == `MSS_OFS_WUNIT;
  wire        wr_ctrl  = we_i && addr_i == `MSS_OFS_CTRL;
  wire        wr_en    = we_i && addr_i == `MSS_OFS_IRQ_EN;
  wire        wr_comm  = we_i && addr_i == `MSS_OFS_COMM;
  wire [`MSS_IRQ_W-1:0] irq_clr =
    (we_i && addr_i == `MSS_OFS_IRQ_CLR) ?
    wdata_i[`MSS_IRQ_W-1:0] : '0;
  wire        seg_page = addr_i[9:8] == `MSS_SEG_PAGE;
  wire [3:0]  seg_sel  = addr_i[7:4];
  wire [1:0]  seg_fld  = addr_i[3:2];
  wire        wr_seg   = we_i && seg_page;
  wire signed [31:0] wd_s = signed'(wdata_i);
  wire signed [31:0] disp_cl = (wd_s > `MSS_DISP_MAX) ? `MSS_DISP_MAX :
                               (wd_s < `MSS_DISP_MIN) ? `MSS_DISP_MIN :
                               wd_s; // RL11
  wire [15:0] speed_cl = (wd16 < `MSS_SPEED_MIN) ? `MSS_SPEED_MIN :
                         (wd16 > `MSS_SPEED_MAX) ? `MSS_SPEED_MAX :
                         wd16; // RL12
  wire [2:0]  meth_cl = (wd16 > {13'h0000, `MSS_METHOD_MAX}) ?
                        `MSS_METHOD_MAX : wd16[2:0]; // RL1

  // ****************************************
  // configuration storage
  // ****************************************
  // restart-effective settings are staged; a ctrl write while not busy
  // (idle or done) applies them, so a running sequence never changes mode midway
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      homing_hold_time        <= `MSS_RST_HOLD;
      method_pend             <= `MSS_RST_METHOD;
      segment_exec_method     <= `MSS_RST_METHOD;
      first_segment_index     <= `MSS_RST_FIRST;
      last_segment_index      <= `MSS_RST_LAST;
      resume_policy           <= `MSS_RST_RESUME;
      pos_pend                <= `MSS_RST_POSTYPE;
      position_reference_type <= `MSS_RST_POSTYPE;
      wait_time_unit          <= `MSS_RST_WUNIT;
      comm_seg                <= `MSS_IDX_MIN;
      irq_en                  <= '0;
    end else begin
      if (wr_hold) homing_hold_time <= wd16;
      if (wr_meth) method_pend <= meth_cl; // RL17
      if (wr_pos) pos_pend <= wdata_i[0]; // RL17
      if (wr_ctrl && wdata_i[0] && !busy_o) begin
        segment_exec_method     <= method_pend; // RL17
        position_reference_type <= pos_pend; // RL17
      end
      if (wr_first)
        first_segment_index <= clamp_idx(wd16, `MSS_IDX_MIN,
                                         last_segment_index); // RL7
      if (wr_last)
        last_segment_index <= clamp_idx(wd16, first_segment_index,
                                        `MSS_IDX_MAX); // RL7
      if (wr_res) resume_policy <= wdata_i[0]; // RL8
      if (wr_wunit) wait_time_unit <= wdata_i[0]; // RL10
      if (wr_comm)
        comm_seg <= clamp_idx(wd16, `MSS_IDX_MIN, `MSS_IDX_MAX); // RL5
      if (wr_en) irq_en <= wdata_i[`MSS_IRQ_W-1:0];
    end
  end

  // segment table: one bank per segment
  for (genvar g = 0; g < `MSS_NSEG; g++) begin : g_seg
    wire hit = wr_seg && seg_sel == 4'(g);
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        seg_disp[g]  <= `MSS_RST_DISP; // RL2
        seg_speed[g] <= `MSS_RST_SPEED;
        seg_ramp[g]  <= `MSS_RST_RAMP;
        seg_wait[g]  <= `MSS_RST_WAIT;
      end else if (hit) begin
        if (seg_fld == `MSS_FLD_DISP) seg_disp[g] <= disp_cl; // RL11
        if (seg_fld == `MSS_FLD_SPEED) seg_speed[g] <= speed_cl; // RL12
        if (seg_fld == `MSS_FLD_RAMP) seg_ramp[g] <= wd16; // RL13
        if (seg_fld == `MSS_FLD_WAIT) seg_wait[g] <= wd16; // RL14
      end
    end
  end

  // ****************************************
  // time base
  // ****************************************
  localparam logic [14:0] TICK_LAST = 15'(CLK_PER_MS - 1);
  localparam logic [9:0]  SEC_LAST  = 10'(`MSS_MS_PER_S - 1);
  wire ms_tick   = tick_cnt == TICK_LAST;
  wire sec_tick  = ms_tick && sub_cnt == SEC_LAST;
  wire unit_tick = wait_time_unit ? sec_tick : ms_tick; // RL10

  // ****************************************
  // sequencer
  // ****************************************
  wire [2:0] mode   = segment_exec_method;
  wire sel_mode  = mode == `MSS_MODE_DI || mode == `MSS_MODE_COMM; // RL5
  wire one_pass  = mode == `MSS_MODE_SINGLE ||
                   mode == `MSS_MODE_SCONT; // RL1
  wire cont_mode = mode == `MSS_MODE_SCONT ||
                   mode == `MSS_MODE_CCONT; // RL6
  wire run_ok    = pos_enable_i && servo_on_command_i;
  wire st_idle   = state == mss_pkg::MSS_IDLE;
  wire st_done   = state == mss_pkg::MSS_DONE;
  wire [4:0] di_idx  = {1'b0, di_seg_sel_i} + `MSS_IDX_MIN;
  wire [4:0] sel_idx = (mode == `MSS_MODE_DI) ? di_idx : comm_seg; // RL5
  wire [4:0] cur_m1  = cur_idx - `MSS_IDX_MIN;
  wire [15:0] cur_wait = seg_wait[cur_m1[3:0]];
  wire at_last   = cur_idx >= last_segment_index;
  wire wait_done = state == mss_pkg::MSS_WAIT && unit_tick &&
                   wait_cnt <= 16'h0001; // RL14
  wire seg_end   = state == mss_pkg::MSS_MOVE && seg_done_i;
  wire [4:0] adv_idx = at_last ? first_segment_index :
                       cur_idx + `MSS_IDX_MIN; // RL4
  wire mss_pkg::mss_state_e adv_state =
    sel_mode ? mss_pkg::MSS_IDLE :
    (at_last && one_pass) ? mss_pkg::MSS_DONE : // RL3
    mss_pkg::MSS_ISSUE;

  always_comb begin
    next_state = state;
    next_cur   = cur_idx;
    if (!run_ok && busy_o) begin
      next_state = mss_pkg::MSS_IDLE; // RL4
    end else begin
      unique case (state)
        mss_pkg::MSS_IDLE, mss_pkg::MSS_DONE: begin
          if (start_i && run_ok) begin
            next_state = mss_pkg::MSS_ISSUE;
            next_cur   = sel_mode ? sel_idx : first_segment_index; // RL3
          end
        end
        mss_pkg::MSS_ISSUE: begin
          if (cmd_ready_i) next_state = mss_pkg::MSS_MOVE;
          else if (pause_i) next_state = mss_pkg::MSS_PAUSE;
        end
        mss_pkg::MSS_MOVE: begin
          if (pause_i) begin
            next_state = mss_pkg::MSS_PAUSE;
          end else if (seg_done_i && cur_wait != 16'h0000) begin
            next_state = mss_pkg::MSS_WAIT; // RL14
          end else if (seg_done_i) begin
            next_state = adv_state;
            next_cur   = sel_mode ? cur_idx : adv_idx; // RL3
          end
        end
        mss_pkg::MSS_WAIT: begin
          if (pause_i) begin
            next_state = mss_pkg::MSS_PAUSE;
          end else if (wait_done) begin
            next_state = adv_state;
            next_cur   = sel_mode ? cur_idx : adv_idx; // RL14
          end
        end
        mss_pkg::MSS_PAUSE: begin
          if (!pause_i) begin
            next_state = mss_pkg::MSS_ISSUE;
            if (resume_policy && !sel_mode)
              next_cur = first_segment_index; // RL8
          end
        end
      endcase
    end
  end

  // command is captured on entry to issue, so its data are flops
  wire [4:0] nxt_m1 = next_cur - `MSS_IDX_MIN;
  wire [3:0] ni     = nxt_m1[3:0];
  wire load_cmd = next_state == mss_pkg::MSS_ISSUE &&
                  state != mss_pkg::MSS_ISSUE;
  wire [`MSS_IRQ_W-1:0] irq_evt;
  assign irq_evt[`MSS_IRQ_SEG]   = seg_end;
  assign irq_evt[`MSS_IRQ_SEQ]   = next_state == mss_pkg::MSS_DONE &&
                                   !st_done;
  assign irq_evt[`MSS_IRQ_HOME]  = homing_done_i;
  assign irq_evt[`MSS_IRQ_PAUSE] = next_state == mss_pkg::MSS_PAUSE &&
                                   state != mss_pkg::MSS_PAUSE;
  wire [15:0] next_hold = homing_done_i ? homing_hold_time :
                          (ms_tick && hold_cnt != 16'h0000) ?
                          hold_cnt - 16'h0001 : hold_cnt; // RL15

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state    <= mss_pkg::MSS_IDLE;
      cur_idx  <= `MSS_IDX_MIN;
      cmd_o    <= '0;
      wait_cnt <= '0;
      sub_cnt  <= '0;
      tick_cnt <= '0;
      hold_cnt <= '0;
      homing_do_o <= 1'b0;
      irq_st   <= '0;
    end else begin
      state    <= next_state;
      cur_idx  <= next_cur;
      tick_cnt <= ms_tick ? '0 : tick_cnt + 15'h0001;
      if (state != mss_pkg::MSS_WAIT) sub_cnt <= '0;
      else if (sec_tick) sub_cnt <= '0;
      else if (ms_tick) sub_cnt <= sub_cnt + 10'h001;
      if (seg_end) wait_cnt <= cur_wait; // RL14
      else if (state == mss_pkg::MSS_WAIT && unit_tick)
        wait_cnt <= wait_cnt - 16'h0001;
      if (load_cmd) begin
        cmd_o.disp     <= seg_disp[ni];
        cmd_o.speed    <= seg_speed[ni]; // RL12
        cmd_o.ramp     <= seg_ramp[ni]; // RL13
        cmd_o.absolute <= position_reference_type; // RL9
        cmd_o.no_stop  <= cont_mode; // RL6
        cmd_o.index    <= next_cur;
      end
      hold_cnt    <= next_hold;
      homing_do_o <= next_hold != 16'h0000; // RL15
      irq_st      <= (irq_st & ~irq_clr) | irq_evt;
    end
  end

  assign cmd_valid_o    = state == mss_pkg::MSS_ISSUE;
  assign busy_o         = !(st_idle || st_done);
  assign seq_complete_o = st_done; // RL18
  assign status_bit12_o = homing_do_o; // RL16
  assign irq_o          = |(irq_st & irq_en);

  // ****************************************
  // read path
  // ****************************************
  wire [31:0] rd_seg =
    (seg_fld == `MSS_FLD_DISP)  ? seg_disp[seg_sel] :
    (seg_fld == `MSS_FLD_SPEED) ? {16'h0000, seg_speed[seg_sel]} :
    (seg_fld == `MSS_FLD_RAMP)  ? {16'h0000, seg_ramp[seg_sel]} :
    {16'h0000, seg_wait[seg_sel]};
  wire [31:0] rd_stat = {13'h0000, cur_idx, state, 4'h0,
                         position_reference_type, segment_exec_method};
  wire [31:0] rd_mux =
    seg_page ? rd_seg :
    (addr_i == `MSS_OFS_HOLD)    ? {16'h0000, homing_hold_time} :
    (addr_i == `MSS_OFS_METHOD)  ? {29'h00000000, method_pend} :
    (addr_i == `MSS_OFS_FIRST)   ? {27'h0000000, first_segment_index} :
    (addr_i == `MSS_OFS_LAST)    ? {27'h0000000, last_segment_index} :
    (addr_i == `MSS_OFS_RESUME)  ? {31'h00000000, resume_policy} :
    (addr_i == `MSS_OFS_POSTYPE) ? {31'h00000000, pos_pend} :
    (addr_i == `MSS_OFS_WUNIT)   ? {31'h00000000, wait_time_unit} :
    (addr_i == `MSS_OFS_STAT)    ? rd_stat :
    (addr_i == `MSS_OFS_IRQ_ST)  ? {28'h0000000, irq_st} :
    (addr_i == `MSS_OFS_IRQ_EN)  ? {28'h0000000, irq_en} :
    (addr_i == `MSS_OFS_COMM)    ? {27'h0000000, comm_seg} : '0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) rdata_o <= '0;
    else rdata_o <= re_i ? rd_mux : '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_go;
    (st_idle || st_done) && start_i && run_ok;
  endsequence
  sequence s_step;
    seg_end && cur_wait == 16'h0000 && run_ok && !pause_i && !sel_mode;
  endsequence

  mode_range_a: assert property (segment_exec_method <= `MSS_METHOD_MAX) // RL1
    else $error("execution method out of range");
  idx_order_a: assert property ( // RL7
    first_segment_index >= `MSS_IDX_MIN &&
    first_segment_index <= last_segment_index &&
    last_segment_index <= `MSS_IDX_MAX)
    else $error("segment indexes out of order");
  first_start_a: assert property ( // RL3
    s_go and !sel_mode |=> cmd_valid_o &&
    cmd_o.index == $past(first_segment_index))
    else $error("run did not begin at first segment");
  sel_start_a: assert property ( // RL5
    s_go and sel_mode |=> cmd_valid_o && cmd_o.index == $past(sel_idx))
    else $error("selected segment not issued");
  step_next_a: assert property ( // RL3
    s_step and !at_last |=> cmd_valid_o &&
    cmd_o.index == $past(cur_idx) + `MSS_IDX_MIN)
    else $error("next segment not issued");
  cyc_wrap_a: assert property ( // RL4
    s_step and (at_last && !one_pass) |=> cmd_valid_o &&
    cmd_o.index == $past(first_segment_index))
    else $error("cyclic run did not wrap");
  pass_stop_a: assert property ( // RL18
    s_step and (at_last && one_pass) |=> seq_complete_o && !cmd_valid_o)
    else $error("one-pass run did not complete");
  wait_hold_a: assert property ( // RL14
    seg_end && cur_wait > 16'h0001 && run_ok && !pause_i
    |=> !cmd_valid_o [*2])
    else $error("wait time skipped");
  cmd_flags_a: assert property ( // RL6
    cmd_valid_o |-> cmd_o.no_stop == cont_mode &&
    cmd_o.absolute == position_reference_type)
    else $error("command flags wrong");
  resume_a: assert property ( // RL8
    state == mss_pkg::MSS_PAUSE && !pause_i && run_ok && !sel_mode
    |=> cmd_o.index == ($past(resume_policy) ?
        $past(first_segment_index) : $past(cur_idx)))
    else $error("resume went to wrong segment");
  abort_a: assert property (busy_o && !run_ok |=> st_idle) // RL4
    else $error("run not stopped on disable");
  home_hold_a: assert property ( // RL15
    homing_done_i && homing_hold_time > 16'h0002
    |=> (homing_do_o && status_bit12_o) [*2])
    else $error("homing output not held");
endmodule

// File: include/mss_cfg.svh
// constants of the multi segment position sequencer
// assumes a 20 MHz clock and a word-aligned register port
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH
// ****************************************
// timing
// ****************************************
`define MSS_CLK_HZ      20000000
`define MSS_MS_PER_S    1000
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MSS_OFS_HOLD    10'h000
`define MSS_OFS_METHOD  10'h004
`define MSS_OFS_FIRST   10'h008
`define MSS_OFS_LAST    10'h00C
`define MSS_OFS_RESUME  10'h010
`define MSS_OFS_POSTYPE 10'h014
`define MSS_OFS_WUNIT   10'h018
`define MSS_OFS_CTRL    10'h01C
`define MSS_OFS_STAT    10'h020
`define MSS_OFS_IRQ_ST  10'h024
`define MSS_OFS_IRQ_CLR 10'h028
`define MSS_OFS_IRQ_EN  10'h02C
`define MSS_OFS_COMM    10'h030
`define MSS_SEG_PAGE    2'h1
`define MSS_FLD_DISP    2'h0
`define MSS_FLD_SPEED   2'h1
`define MSS_FLD_RAMP    2'h2
`define MSS_FLD_WAIT    2'h3
// ****************************************
// reset values and limits
// ****************************************
`define MSS_RST_HOLD    16'h07D0
`define MSS_RST_METHOD  3'h0
`define MSS_RST_FIRST   5'h01
`define MSS_RST_LAST    5'h02
`define MSS_RST_RESUME  1'h1
`define MSS_RST_POSTYPE 1'h0
`define MSS_RST_WUNIT   1'h0
`define MSS_RST_DISP    32'h00002710
`define MSS_RST_SPEED   16'h00C8
`define MSS_RST_RAMP    16'h000A
`define MSS_RST_WAIT    16'h0000
`define MSS_DISP_MAX    32'sh7FFFFFFE
`define MSS_DISP_MIN    32'sh80000002
`define MSS_SPEED_MIN   16'h0001
`define MSS_SPEED_MAX   16'h2328
`define MSS_METHOD_MAX  3'h5
`define MSS_IDX_MIN     5'h01
`define MSS_IDX_MAX     5'h10
`define MSS_NSEG        16
// ****************************************
// modes and interrupt bits
// ****************************************
`define MSS_MODE_SINGLE 3'h0
`define MSS_MODE_CYCLIC 3'h1
`define MSS_MODE_DI     3'h2
`define MSS_MODE_COMM   3'h3
`define MSS_MODE_SCONT  3'h4
`define MSS_MODE_CCONT  3'h5
`define MSS_IRQ_W       4
`define MSS_IRQ_SEG     0
`define MSS_IRQ_SEQ     1
`define MSS_IRQ_HOME    2
`define MSS_IRQ_PAUSE   3
`endif

// File: include/mss_pkg.sv
// types of the multi segment position sequencer
// assumes mss_cfg.svh for all numeric constants
package mss_pkg;
  typedef enum logic [5:0] {
    MSS_IDLE  = 6'b000001,
    MSS_ISSUE = 6'b000010,
    MSS_MOVE  = 6'b000100,
    MSS_WAIT  = 6'b001000,
    MSS_PAUSE = 6'b010000,
    MSS_DONE  = 6'b100000
  } mss_state_e;
  typedef struct packed {
    logic signed [31:0] disp;
    logic [15:0]        speed;
    logic [15:0]        ramp;
    logic               absolute;
    logic               no_stop;
    logic [4:0]         index;
  } mss_cmd_s;
endpackage

// File: bench/mss_traj_model.sv
// trajectory generator model facing the sequencer's command port
// assumes commands by valid/ready; the move lasts 3 cycles, 10 when slow
`timescale 1ns/100ps
module mss_traj_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic cmd_valid_i,
  input  wire logic slow_i,
  output logic      cmd_ready_o,
  output logic      seg_done_o
);
  // ****************************************
  // accept, move, report
  // ****************************************
  logic [3:0] cnt;
  logic       moving;
  // ready is registered, so it never answers in the cycle valid appears
  always_ff @(posedge clk_i) begin
    seg_done_o <= 1'b0;
    if (!rst_n_i) begin
      cnt         <= 4'h0;
      moving      <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else if (moving) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        moving     <= 1'b0;
        seg_done_o <= 1'b1;
      end
    end else if (cmd_ready_o && cmd_valid_i) begin
      cmd_ready_o <= 1'b0;
      moving      <= 1'b1;
      cnt         <= slow_i ? 4'hA : 4'h3;
    end else begin
      cmd_ready_o <= cmd_valid_i;
    end
  end
endmodule

// File: bench/tb.sv
// self-checking testbench of the multi segment position sequencer
// assumes the ms tick shortened to 4 clock cycles
`timescale 1ns/100ps
module tb;
  logic              clk_i, rst_n_i, we_i, re_i, start_i, pause_i;
  logic              servo_on_command_i, pos_enable_i, homing_done_i, slow;
  logic              cmd_ready_i, seg_done_i, cmd_valid_o, busy_o, irq_o;
  logic              seq_complete_o, homing_do_o, status_bit12_o;
  logic [9:0]        addr_i;
  logic [31:0]       wdata_i, rdata_o, rv;
  logic [3:0]        di_seg_sel_i;
  mss_pkg::mss_cmd_s cmd_o;
  int                fail_count, comparisons, cycles;
  mss_seq #(.CLK_PER_MS(4)) mss_seq_i (.clk_i, .rst_n_i, .addr_i, .wdata_i,
    .we_i, .re_i, .rdata_o, .servo_on_command_i, .pos_enable_i, .start_i,
    .pause_i, .di_seg_sel_i, .cmd_ready_i, .seg_done_i, .homing_done_i,
    .cmd_valid_o, .cmd_o, .busy_o, .seq_complete_o, .homing_do_o,
    .status_bit12_o, .irq_o);
  mss_traj_model mss_traj_model_i (.clk_i, .rst_n_i, .slow_i(slow),
    .cmd_valid_i(cmd_valid_o), .cmd_ready_o(cmd_ready_i),
    .seg_done_o(seg_done_i));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic tick(); @(posedge clk_i); #1; endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i) {we_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i) we_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_i) {re_i, addr_i} <= {1'b1, a};
    @(posedge clk_i) re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wrd(input logic [9:0] a, input logic [31:0] d, e);
    wr(a, d);
    rd(a, rv);
    cmp(rv, e);
  endtask
  task automatic go();
    @(posedge clk_i) start_i <= 1'b1;
    @(posedge clk_i) start_i <= 1'b0;
  endtask
  // bounded wait for the next command; checks its delay and segment
  task automatic nxt(input int lo, input int hi, input logic [4:0] ix);
    int n;
    n = 0;
    do begin tick(); n++; end while (cmd_valid_o !== 1'b1 && n < hi);
    cmp(n >= lo && n <= hi && cmd_valid_o === 1'b1, 1);
    cmp(cmd_o.index, ix);
  endtask
  task automatic done_wait();
    int n;
    n = 0;
    while (seg_done_i !== 1'b1 && n < 100) begin tick(); n++; end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [9:0]  a [10] = '{10'h000, 10'h004, 10'h008, 10'h00C, 10'h010,
                            10'h014, 10'h100, 10'h104, 10'h108, 10'h3FC};
    logic [31:0] e [10] = '{32'h7D0, 32'h0, 32'h1, 32'h2, 32'h1, 32'h0,
                            32'h2710, 32'hC8, 32'hA, 32'h0};
    foreach (a[i]) begin rd(a[i], rv); cmp(rv, e[i]); end
    $display("test regs done");
  endtask
  task automatic t_clamp();
    wrd(10'h008, 32'h0, 32'h1);
    wrd(10'h00C, 32'h11, 32'h10);
    wrd(10'h00C, 32'h2, 32'h2);
    wrd(10'h008, 32'h5, 32'h2);
    wrd(10'h008, 32'h1, 32'h1);
    wrd(10'h100, 32'h7FFFFFFF, 32'h7FFFFFFE);
    wrd(10'h100, 32'h80000000, 32'h80000002);
    wrd(10'h100, 32'h2710, 32'h2710);
    wrd(10'h104, 32'h0, 32'h1);
    wrd(10'h104, 32'h270F, 32'h2328);
    wrd(10'h108, 32'hFFFF, 32'hFFFF);
    wrd(10'h004, 32'h7, 32'h5);
    wrd(10'h004, 32'h0, 32'h0);
    $display("test clamp done");
  endtask
  task automatic t_onepass();
    slow <= 1'b1;
    wr(10'h10C, 32'h2);
    wr(10'h02C, 32'hF);
    go();
    nxt(1, 1, 5'h01);
    cmp({cmd_o.no_stop, cmd_o.absolute, cmd_o.speed}, 32'h2328);
    cmp(cmd_o.disp, 32'h2710);
    cmp(cmd_o.ramp, 32'hFFFF);
    done_wait();
    nxt(3, 14, 5'h02);
    done_wait();
    tick();
    cmp({seq_complete_o, busy_o, irq_o}, 3'b101);
    rd(10'h024, rv);
    cmp(rv[1:0], 2'b11);
    wr(10'h02C, 32'h0);
    tick();
    cmp(irq_o, 1'b0);
    wr(10'h028, 32'hF);
    wr(10'h02C, 32'hF);
    rd(10'h024, rv);
    cmp(rv | 32'(irq_o), 32'h0);
    wr(10'h10C, 32'h1);
    wr(10'h018, 32'h1);
    go();
    nxt(1, 1, 5'h01);
    done_wait();
    nxt(3900, 4100, 5'h02);
    done_wait();
    wr(10'h018, 32'h0);
    wr(10'h10C, 32'h0);
    slow <= 1'b0;
    $display("test onepass done");
  endtask
  task automatic t_pause();
    wr(10'h004, 32'h1);
    wr(10'h014, 32'h1);
    rd(10'h020, rv);
    cmp(rv[3:0], 4'h0);
    wr(10'h01C, 32'h1);
    rd(10'h020, rv);
    cmp(rv[3:0], 4'h9);
    go();
    nxt(1, 1, 5'h01);
    cmp(cmd_o.absolute, 1'b1);
    done_wait();
    nxt(1, 1, 5'h02);
    @(posedge clk_i) pause_i <= 1'b1;
    repeat (3) tick();
    rd(10'h020, rv);
    cmp(rv[13:8], 6'h10);
    @(posedge clk_i) pause_i <= 1'b0;
    nxt(1, 8, 5'h01);
    done_wait();
    nxt(1, 1, 5'h02);
    done_wait();
    nxt(1, 1, 5'h01);
    servo_on_command_i <= 1'b0;
    tick();
    tick();
    cmp(busy_o, 1'b0);
    servo_on_command_i <= 1'b1;
    wr(10'h014, 32'h0);
    $display("test pause done");
  endtask
  task automatic t_modes();
    di_seg_sel_i <= 4'h4;
    wr(10'h030, 32'h7);
    for (int i = 0; i < 6; i++) begin
      wr(10'h004, i);
      wr(10'h01C, 32'h1);
      go();
      nxt(1, 1, i == 2 ? 5'h05 : i == 3 ? 5'h07 : 5'h01);
      cmp(cmd_o.no_stop, i >= 4);
      done_wait();
      if (i < 2 || i > 3) begin nxt(1, 1, 5'h02); done_wait(); end
      if (i == 1 || i == 5) begin nxt(1, 1, 5'h01); pos_enable_i <= 1'b0; end
      tick();
      tick();
      cmp(busy_o, 1'b0);
      pos_enable_i <= 1'b1;
    end
    $display("test modes done");
  endtask
  task automatic t_homing();
    int n;
    wr(10'h000, 32'h3);
    @(posedge clk_i) homing_done_i <= 1'b1;
    @(posedge clk_i) homing_done_i <= 1'b0;
    tick();
    cmp(homing_do_o, 1'b1);
    n = 0;
    while (homing_do_o === 1'b1 && n < 40) begin
      cmp(status_bit12_o, 1'b1);
      tick();
      n++;
    end
    cmp(n >= 7 && n <= 16, 1);
    cmp(status_bit12_o, 1'b0);
    rd(10'h024, rv);
    cmp(rv[2], 1'b1);
    wr(10'h000, 32'h0);
    @(posedge clk_i) homing_done_i <= 1'b1;
    @(posedge clk_i) homing_done_i <= 1'b0;
    tick();
    cmp({homing_do_o, status_bit12_o}, 2'b00);
    $display("test homing done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // whole run is about 4400 cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    {addr_i, wdata_i, we_i, re_i, start_i, pause_i} = '0;
    {di_seg_sel_i, homing_done_i, slow, rst_n_i} = '0;
    {servo_on_command_i, pos_enable_i} = 2'b11;
    {fail_count, comparisons, cycles} = '0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_clamp();
    t_onepass();
    t_pause();
    t_modes();
    t_homing();
    report_and_stop();
  end
endmodule
